// ==== hw/ppcl_top.sv ====
// Purpose: One pulse channel with position counter and coordinate logic.
// Assumes: Single AHB-Lite slave, zero wait states, OKAY answers only.
// Notes:   Direction high is clockwise; pulse is one cycle wide.
`timescale 1ns/1ps
module ppcl_top (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic      [31:0] hrdata,
   output logic             hresp,
   input  wire logic        program_mode,
   output logic             pulse_out,
   output logic             dir_cw,
   output logic             origin_undefined,
   output logic             irq
);
   import ppcl_pkg::*;

   ppcl_state_e        state;
   logic               act_q;
   logic               wr_q;
   logic        [7:0]  addr_q;
   logic        [31:0] setting;
   logic        [31:0] start_per;
   logic        [31:0] min_per;
   logic        [31:0] step;
   logic signed [31:0] position;
   logic        [31:0] remain;
   logic        [31:0] period;
   logic        [31:0] tick;
   logic        [31:0] ramp_cnt;
   logic               ramp_on;
   logic [IRQ_W-1:0]   int_stat;
   logic [IRQ_W-1:0]   int_en;
   logic               pm_s1;
   logic               pm_s2;
   logic               pm_s3;
   logic               wr_en;
   logic               cmd_wr;
   logic               go_rel;
   logic               go_abs;
   logic               abs_err;
   logic               chan_rst;
   logic               set_pv;
   logic               prog_entry;
   logic               fire;
   logic               done_ev;
   logic signed [32:0] diff;
   logic        [32:0] diff_mag;

   // Read multiplexer for the register map
   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      logic [31:0] v;
      v = ZERO_W;
      unique case (a)
         ADDR_SETTING:   v = setting;
         ADDR_START_PER: v = start_per;
         ADDR_MIN_PER:   v = min_per;
         ADDR_STEP:      v = step;
         ADDR_POSITION:  v = position;
         ADDR_REMAIN:    v = remain;
         ADDR_INT_STAT:  v = {{(32-IRQ_W){1'b0}}, int_stat};
         ADDR_INT_EN:    v = {{(32-IRQ_W){1'b0}}, int_en};
         ADDR_STATUS: begin
            v[ST_BUSY]  = (state == PPCL_RUN);
            v[ST_NOORG] = origin_undefined;
            v[ST_DIR]   = dir_cw;
            v[ST_RAMP]  = ramp_on;
         end
         default:        v = ZERO_W;
      endcase
      return v;
   endfunction

   // Bus answers: always ready, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase capture and registered read data
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         act_q  <= 1'b0;
         wr_q   <= 1'b0;
         addr_q <= 8'h00;
         hrdata <= ZERO_W;
      end else if (hready) begin
         act_q  <= hsel && (htrans == HTRANS_NONSEQ);
         wr_q   <= hwrite;
         addr_q <= {haddr[7:2], 2'b00};
         if (hsel && (htrans == HTRANS_NONSEQ) && !hwrite) begin
            hrdata <= rd_mux({haddr[7:2], 2'b00});
         end
      end
   end

   // Programming-mode input synchroniser
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pm_s1 <= 1'b0;
         pm_s2 <= 1'b0;
         pm_s3 <= 1'b0;
      end else begin
         pm_s1 <= program_mode;
         pm_s2 <= pm_s1;
         pm_s3 <= pm_s2;
      end
   end

   // Command decode
   assign wr_en      = act_q && wr_q;
   assign cmd_wr     = wr_en && (addr_q == ADDR_CTRL);
   assign prog_entry = pm_s2 && !pm_s3;
   assign chan_rst   = cmd_wr && hwdata[CB_RESET];
   assign set_pv     = cmd_wr && hwdata[CB_SETPV] && (state == PPCL_IDLE);
   assign go_rel     = cmd_wr && hwdata[CB_REL] && (state == PPCL_IDLE)
                       && !chan_rst;
   assign abs_err    = cmd_wr && hwdata[CB_ABS] && (state == PPCL_IDLE)
                       && origin_undefined && !chan_rst && !go_rel; // R6
   assign go_abs     = cmd_wr && hwdata[CB_ABS] && (state == PPCL_IDLE)
                       && !origin_undefined && !chan_rst && !go_rel;
   // Target minus present position, widened so no overflow
   assign diff       = $signed({setting[31], setting})
                       - $signed({position[31], position}); // R7
   assign diff_mag   = diff[32] ? 33'(-diff) : 33'(diff); // R14
   assign fire       = (state == PPCL_RUN) && (tick == ZERO_W)
                       && (remain != ZERO_W);
   assign done_ev    = (state == PPCL_RUN) && (remain == ZERO_W);

   // Simple settings registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         setting   <= ZERO_W;
         start_per <= START_PER_RST;
         min_per   <= MIN_PER_RST;
         step      <= STEP_RST;
         int_en    <= '0;
      end else if (wr_en) begin
         unique case (addr_q)
            ADDR_SETTING:   setting   <= hwdata;
            ADDR_START_PER: start_per <= hwdata;
            ADDR_MIN_PER:   min_per   <= hwdata;
            ADDR_STEP:      step      <= hwdata;
            ADDR_INT_EN:    int_en    <= hwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Origin tracking: undefine wins over define
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         origin_undefined <= 1'b1;
      end else if (chan_rst) begin
         origin_undefined <= 1'b1; // R9
      end else if (prog_entry) begin
         origin_undefined <= 1'b1; // R10
      end else if (set_pv || (cmd_wr && hwdata[CB_ORIGIN])) begin
         origin_undefined <= 1'b0; // R8 R13
      end
   end

   // Channel state machine
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state <= PPCL_IDLE;
      end else begin
         unique case (state)
            PPCL_IDLE: begin
               if (go_rel || go_abs) begin
                  state <= PPCL_RUN;
               end
            end
            PPCL_RUN: begin
               if (chan_rst || done_ev) begin
                  state <= PPCL_IDLE;
               end
            end
            default: state <= PPCL_IDLE;
         endcase
      end
   end

   // Move count, direction and ramp choice at start
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         remain  <= ZERO_W;
         dir_cw  <= 1'b1;
         ramp_on <= 1'b0;
      end else if (chan_rst) begin
         remain <= ZERO_W;
      end else if (go_rel) begin
         remain  <= setting; // R1 R5
         dir_cw  <= !hwdata[CB_CCW];
         ramp_on <= hwdata[CB_RAMP];
      end else if (go_abs) begin
         remain  <= diff_mag[31:0]; // R7 R14
         dir_cw  <= !diff[32] && (diff != 33'sd0); // R14
         ramp_on <= hwdata[CB_RAMP];
      end else if (fire) begin
         remain <= remain - ONE_W; // R1
      end
   end

   // Position counter, signed and wrapping in two's complement
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         position <= '0;
      end else if (chan_rst) begin
         position <= '0;
      end else if (set_pv) begin
         position <= setting; // R13
      end else if (go_rel && origin_undefined) begin
         position <= '0; // R2
      end else if (fire) begin
         position <= dir_cw ? position + 32'sd1
                            : position - 32'sd1; // R3 R4
      end
   end

   // Pulse timing with ramp up, hold and ramp down
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tick     <= ZERO_W;
         period   <= START_PER_RST;
         ramp_cnt <= ZERO_W;
      end else if (go_rel || go_abs) begin
         tick     <= ZERO_W;
         period   <= hwdata[CB_RAMP] ? start_per : min_per;
         ramp_cnt <= ZERO_W;
      end else if (fire) begin
         tick <= period - ONE_W;
         if (ramp_on && (remain <= ramp_cnt + ONE_W)) begin
            // Slow down for as many pulses as were spent speeding up
            period   <= (period + step > start_per) ? start_per
                                                    : period + step; // R12
            ramp_cnt <= (ramp_cnt == ZERO_W) ? ZERO_W : ramp_cnt - ONE_W;
         end else if (ramp_on && (period > min_per)) begin
            period   <= (period - min_per > step) ? period - step
                                                  : min_per; // R12
            ramp_cnt <= ramp_cnt + ONE_W;
         end
      end else if ((state == PPCL_RUN) && (tick != ZERO_W)) begin
         tick <= tick - ONE_W;
      end
   end

   // Pulse output register
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pulse_out <= 1'b0;
      end else begin
         pulse_out <= fire; // R1
      end
   end

   // Sticky interrupt status, a set beats a clear
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         int_stat <= '0;
      end else begin
         for (int i = 0; i < IRQ_W; i++) begin
            if ((i == IRQ_DONE && done_ev) || (i == IRQ_ERR && abs_err)) begin
               int_stat[i] <= 1'b1; // R6
            end else if (wr_en && addr_q == ADDR_INT_CLR && hwdata[i]) begin
               int_stat[i] <= 1'b0;
            end
         end
      end
   end

   // Level interrupt from enabled status
   assign irq = |(int_stat & int_en);

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   logic signed [31:0] pos_start;
   logic        [31:0] pulse_seen;
   logic        [31:0] move_len;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pulse_seen <= ZERO_W;
         move_len   <= ZERO_W;
         pos_start  <= '0;
      end else if (go_rel || go_abs) begin
         pulse_seen <= ZERO_W;
         move_len   <= go_rel ? setting : diff_mag[31:0];
         pos_start  <= (go_rel && origin_undefined) ? 32'sd0 : position;
      end else if (fire) begin
         pulse_seen <= pulse_seen + ONE_W;
      end
   end

   rel_count_a: assert property ( // R1
      done_ev && !chan_rst |-> pulse_seen == move_len)
      else $error("move ended with wrong pulse count");
   rel_clear_a: assert property ( // R2
      go_rel && origin_undefined && !set_pv |=> position == 32'sd0)
      else $error("position not cleared at relative start");
   rel_keep_a: assert property ( // R3
      go_rel && !origin_undefined && !set_pv
      |=> position == $past(position))
      else $error("position lost at relative start");
   pos_track_a: assert property ( // R3 R4
      done_ev |-> position == (dir_cw ? pos_start + $signed(move_len)
                                      : pos_start - $signed(move_len)))
      else $error("final position wrong");
   abs_refuse_a: assert property ( // R6
      abs_err |=> state == PPCL_IDLE && int_stat[IRQ_ERR] && !pulse_out)
      else $error("absolute move without origin not refused");
   abs_dir_a: assert property ( // R7 R14
      go_abs |=> dir_cw == ($signed(setting) > position)
                 && remain == diff_mag[31:0])
      else $error("absolute direction or count wrong");
   org_flag_a: assert property ( // R8 R13
      set_pv && !chan_rst && !prog_entry |=> !origin_undefined)
      else $error("origin not defined by position write");
   chan_rst_a: assert property ( // R9
      chan_rst |=> origin_undefined && state == PPCL_IDLE)
      else $error("channel reset did not undefine origin");
   prog_mode_a: assert property ( // R10
      $rose(pm_s2) |=> origin_undefined)
      else $error("program mode did not undefine origin");
   ramp_peak_a: assert property ( // R12
      fire && ramp_on |=> period >= min_per && period <= start_per)
      else $error("ramp period outside limits");
   idle_quiet_a: assert property (
      state == PPCL_IDLE |=> !pulse_out)
      else $error("pulse while idle");

   rel_move_c:  cover property (go_rel ##[1:300] done_ev);
   abs_move_c:  cover property (go_abs && !dir_cw ##[1:300] done_ev);
   abs_err_c:   cover property (abs_err ##1 irq);
   triangle_c:  cover property (fire && ramp_on && period > min_per
                                && remain <= ramp_cnt + ONE_W);
endmodule

// ==== shared/ppcl_pkg.sv ====
// Purpose: Constants and types for the pulse position coordinate logic.
// Assumes: AHB-Lite word registers, one pulse channel, 125 MHz clock.
// Notes:   Operation list below; periods are in clock cycles.
//
// Operation
// R1: A relative move emits exactly the commanded number of pulses.
// R2: A relative move with no origin clears the position to 0 first.
// R3: A relative move with an origin adds the moved count to the position.
// R4: The position counter is signed 32-bit, 8000_0000 to 7FFF_FFFF hex.
// R5: Software gives a pulse setting from 0 to 7FFF_FFFF hex.
// R6: An absolute move with no origin is refused with an error, no pulses.
// R7: An absolute move derives count and direction from target and position.
// R8: The origin-undefined flag is high in relative coordinates only.
// R9: The channel reset command makes the origin undefined again.
// R10: Entering programming mode makes the origin undefined.
// R11: Software asks for absolute moves only after an origin exists.
// R12: An unreachable peak rate is lowered, giving a triangular profile.
// R13: The origin is defined by a finished search or a position write.
// R14: Absolute moves go clockwise when target exceeds position, count |d|.
package ppcl_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_SETTING   = 8'h04;
   localparam logic [7:0] ADDR_START_PER = 8'h08;
   localparam logic [7:0] ADDR_MIN_PER   = 8'h0C;
   localparam logic [7:0] ADDR_STEP      = 8'h10;
   localparam logic [7:0] ADDR_POSITION  = 8'h14;
   localparam logic [7:0] ADDR_STATUS    = 8'h18;
   localparam logic [7:0] ADDR_INT_STAT  = 8'h1C;
   localparam logic [7:0] ADDR_INT_CLR   = 8'h20;
   localparam logic [7:0] ADDR_INT_EN    = 8'h24;
   localparam logic [7:0] ADDR_REMAIN    = 8'h28;
   // Command bits of the control register
   localparam int CB_REL    = 0;
   localparam int CB_ABS    = 1;
   localparam int CB_SETPV  = 2;
   localparam int CB_ORIGIN = 3;
   localparam int CB_RESET  = 4;
   localparam int CB_CCW    = 5;
   localparam int CB_RAMP   = 6;
   // Status bits
   localparam int ST_BUSY  = 0;
   localparam int ST_NOORG = 1;
   localparam int ST_DIR   = 2;
   localparam int ST_RAMP  = 3;
   // Interrupt bits
   localparam int IRQ_W    = 2;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR  = 1;
   // Reset values and shared constants
   localparam logic [31:0] START_PER_RST = 32'h0000_0100;
   localparam logic [31:0] MIN_PER_RST   = 32'h0000_0010;
   localparam logic [31:0] STEP_RST      = 32'h0000_0001;
   localparam logic [31:0] ZERO_W        = 32'h0000_0000;
   localparam logic [31:0] ONE_W         = 32'h0000_0001;
   localparam logic [31:0] POS_MAX       = 32'h7FFF_FFFF;
   localparam logic [31:0] POS_MIN       = 32'h8000_0000;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   // Channel states
   typedef enum logic [1:0] {
      PPCL_IDLE = 2'b01,
      PPCL_RUN  = 2'b10
   } ppcl_state_e;
endpackage

// ==== tb/ppcl_motor_model.sv ====
// Purpose: Motor drive stand-in that counts pulses and steps.
// Assumes: One step per pulse_out cycle, dir_cw high is clockwise.
// Notes:   Clear input restarts counts before each move.
`timescale 1ns/1ps
module ppcl_motor_model (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        clr,
   input  wire logic        pulse_out,
   input  wire logic        dir_cw,
   output logic      [31:0] n_pulse,
   output logic      [31:0] net_steps,
   output logic      [31:0] min_gap,
   output logic             last_cw
);
   logic [31:0] gap;
   // Step counting and shortest pulse spacing
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         n_pulse <= 32'h0000_0000;
         net_steps <= 32'h0000_0000;
         min_gap <= 32'hFFFF_FFFF;
         gap <= 32'h0000_0000;
         last_cw <= 1'b1;
      end else if (clr) begin
         n_pulse <= 32'h0000_0000;
         net_steps <= 32'h0000_0000;
         min_gap <= 32'hFFFF_FFFF;
      end else if (pulse_out) begin
         n_pulse <= n_pulse + 32'h0000_0001;
         net_steps <= dir_cw ? net_steps + 32'h0000_0001
                             : net_steps - 32'h0000_0001;
         last_cw <= dir_cw;
         gap <= 32'h0000_0001;
         if (n_pulse != 32'h0000_0000 && gap < min_gap) begin
            min_gap <= gap;
         end
      end else begin
         gap <= gap + 32'h0000_0001;
      end
   end
endmodule

// ==== tb/ppcl_top_tb.sv ====
// Purpose: Self-checking bench for the pulse position coordinate logic.
// Assumes: Zero-wait AHB-Lite slave; motor model counts the pulses.
// Notes:   Moves are judged by pulse count, direction and position.
`timescale 1ns/1ps
module ppcl_top_tb;
   import ppcl_pkg::*;
   logic        clock, reset, hsel, hwrite, program_mode, clr;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0]  htrans;
   wire  logic  hreadyout, pulse_out, dir_cw, origin_undefined, irq;
   wire  logic  hresp;
   wire  logic  last_cw;
   wire  logic [31:0] hrdata, n_pulse, net_steps, min_gap;
   int          n_mismatch = 0, checked = 0, cycles = 0;

   ppcl_top u_ppcl_top (.clock(clock), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .program_mode(program_mode),
      .pulse_out(pulse_out), .dir_cw(dir_cw),
      .origin_undefined(origin_undefined), .irq(irq));
   ppcl_motor_model u_ppcl_motor_model (.clock(clock), .reset(reset),
      .clr(clr), .pulse_out(pulse_out), .dir_cw(dir_cw),
      .n_pulse(n_pulse), .net_steps(net_steps), .min_gap(min_gap),
      .last_cw(last_cw));

   // Clock at 125 MHz
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_mismatch++;
         test_done;
      end
   end

   // Verdict and end of run
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Compare seen against expected
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One single AHB-Lite word transfer, read data left in rd
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, ZERO_W);
      chk(rd, exp);
      chk({31'h0, hresp}, ZERO_W);
   endtask

   // Load setting, issue command, poll until idle
   task automatic move(input logic [31:0] s, input logic [31:0] c);
      int i;
      clr <= 1'b1;
      bus(1'b1, ADDR_SETTING, s);
      clr <= 1'b0;
      bus(1'b1, ADDR_CTRL, c);
      i = 0;
      do begin
         bus(1'b0, ADDR_STATUS, ZERO_W);
         i++;
      end while (rd[ST_BUSY] !== 1'b0 && i < 300);
      chk({31'h0, rd[ST_BUSY]}, ZERO_W);
   endtask

   // Reset values, unmapped read, fast period for later moves
   task automatic t_reset_vals;
      chk({31'h0, origin_undefined}, ONE_W);
      rdchk(ADDR_START_PER, START_PER_RST);
      rdchk(ADDR_MIN_PER, MIN_PER_RST);
      rdchk(ADDR_STEP, STEP_RST);
      rdchk(ADDR_INT_EN, ZERO_W);
      rdchk(ADDR_POSITION, ZERO_W);
      rdchk(8'h3C, ZERO_W);
      bus(1'b1, ADDR_MIN_PER, 32'h0000_0002);
   endtask

   // Relative moves without origin restart the count from zero
   task automatic t_rel_noorg;
      move(32'h0000_0003, 32'h0000_0001);
      chk(n_pulse, 32'h0000_0003);
      rdchk(ADDR_POSITION, 32'h0000_0003);
      rdchk(ADDR_REMAIN, ZERO_W);
      move(32'h0000_0002, 32'h0000_0021);
      chk(n_pulse, 32'h0000_0002);
      chk({31'h0, last_cw}, ZERO_W);
      rdchk(ADDR_POSITION, 32'hFFFF_FFFE);
      chk({31'h0, origin_undefined}, ONE_W);
   endtask

   // Absolute move without origin: error event, irq, mask and clear
   task automatic t_abs_err;
      bus(1'b1, ADDR_INT_CLR, 32'h0000_0003);
      bus(1'b1, ADDR_INT_EN, 32'h0000_0003);
      move(32'h0000_0005, 32'h0000_0002);
      chk(n_pulse, ZERO_W);
      rdchk(ADDR_INT_STAT, 32'h0000_0002);
      chk({31'h0, irq}, ONE_W);
      bus(1'b1, ADDR_INT_EN, ONE_W);
      #1;
      chk({31'h0, irq}, ZERO_W);
      bus(1'b1, ADDR_INT_CLR, 32'h0000_0002);
      rdchk(ADDR_INT_STAT, ZERO_W);
   endtask

   // Position write defines origin; relative and absolute moves
   task automatic t_origin_moves;
      bus(1'b1, ADDR_SETTING, 32'h0000_000A);
      bus(1'b1, ADDR_CTRL, 32'h0000_0004);
      #1;
      chk({31'h0, origin_undefined}, ZERO_W);
      move(32'h0000_0003, 32'h0000_0021);
      chk(n_pulse, 32'h0000_0003);
      rdchk(ADDR_POSITION, 32'h0000_0007);
      move(32'h0000_000C, 32'h0000_0002);
      chk(n_pulse, 32'h0000_0005);
      chk({31'h0, last_cw}, ONE_W);
      rdchk(ADDR_POSITION, 32'h0000_000C);
      rdchk(ADDR_STATUS, 32'h0000_0004);
      move(32'hFFFF_FFFD, 32'h0000_0002);
      chk(n_pulse, 32'h0000_000F);
      chk({31'h0, last_cw}, ZERO_W);
      chk(net_steps, 32'hFFFF_FFF1);
      rdchk(ADDR_INT_STAT, ONE_W);
      chk({31'h0, irq}, ONE_W);
      bus(1'b1, ADDR_SETTING, POS_MAX);
      bus(1'b1, ADDR_CTRL, 32'h0000_0004);
      move(ONE_W, ONE_W);
      rdchk(ADDR_POSITION, POS_MIN);
   endtask

   // Channel reset and programming mode undefine the origin
   task automatic t_undefine;
      // Long move cut short by the channel reset
      bus(1'b1, ADDR_SETTING, 32'h0000_0100);
      bus(1'b1, ADDR_CTRL, ONE_W);
      bus(1'b1, ADDR_CTRL, 32'h0000_0010);
      #1;
      chk({31'h0, origin_undefined}, ONE_W);
      rdchk(ADDR_POSITION, ZERO_W);
      rdchk(ADDR_STATUS, 32'h0000_0006);
      rdchk(ADDR_REMAIN, ZERO_W);
      move(32'h0000_0005, 32'h0000_0002);
      chk(n_pulse, ZERO_W);
      bus(1'b1, ADDR_CTRL, 32'h0000_0008);
      #1;
      chk({31'h0, origin_undefined}, ZERO_W);
      @(posedge clock);
      program_mode <= 1'b1;
      repeat (6) @(posedge clock);
      chk({31'h0, origin_undefined}, ONE_W);
      program_mode <= 1'b0;
   endtask

   // Short ramped move never reaches the peak rate
   task automatic t_ramp;
      bus(1'b1, ADDR_START_PER, 32'h0000_0020);
      bus(1'b1, ADDR_STEP, 32'h0000_0004);
      move(32'h0000_0004, 32'h0000_0041);
      chk(n_pulse, 32'h0000_0004);
      chk({31'h0, min_gap > 32'h0000_0002}, ONE_W);
      rdchk(ADDR_STATUS, 32'h0000_000E);
   endtask

   // Main sequence
   initial begin
      reset = 1'b1;
      hsel = 1'b0;
      haddr = ZERO_W;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = ZERO_W;
      program_mode = 1'b0;
      clr = 1'b0;
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      t_reset_vals;
      t_rel_noorg;
      t_abs_err;
      t_origin_moves;
      t_undefine;
      t_ramp;
      test_done;
   end
endmodule
